// ### led_ctl_defines.svh
// constants for the led driver control register bank
// Notes on behaviour
// - overheat blanks leds, stops boost, keeps registers
// - latched short blocks self restore after overheat
// - input overvoltage pauses boost, resumes by itself
// - no writes or reset without logic supply
// - output droop for 10 ms latches regulator stop
// - latch clears on reset or regulator enable zero
// - in fixed mode led pin droop latches the same way instead
// - all map registers write only, reset zero
// - settings one: standby, regulator, fixed, switches
// - settings two: eight single bit controls
// - settings three: sync and rgb per group
// - settings four: flash, key, main flash bits
// - main current: normal and dim codes
// - channel current codes, ch6 voltage setting
// - red and flash max range fields
// - fade registers: out and in times
// - gradation holds, mode, enable, timing
// - pulse enable, period and hold fields
// - six bit off and on positions
`ifndef LED_CTL_DEFINES_SVH
`define LED_CTL_DEFINES_SVH
`define A_SET_ONE 5'h00
`define A_SET_TWO 5'h01
`define A_SET_THREE 5'h02
`define A_SET_FOUR 5'h03
`define A_MAIN_CUR 5'h04
`define A_M4_CUR 5'h05
`define A_M5_CUR 5'h06
`define A_M6_CUR 5'h07
`define A_S1_CUR 5'h08
`define A_S2_CUR 5'h09
`define A_R1_CUR 5'h0a
`define A_G1_CUR 5'h0b
`define A_B1_CUR 5'h0c
`define A_R2_CUR 5'h0d
`define A_G2_CUR 5'h0e
`define A_B2_CUR 5'h0f
`define A_F1_CUR 5'h10
`define A_F2_CUR 5'h11
`define A_F3_CUR 5'h12
`define A_MAIN_FADE 5'h13
`define A_SUB_FADE 5'h14
`define A_R1_FADE 5'h15
`define A_G1_FADE 5'h16
`define A_B1_FADE 5'h17
`define A_GRAD 5'h18
`define A_PULSE 5'h19
`define A_R1_OFF 5'h1a
`define A_R1_ON 5'h1b
`define A_G1_OFF 5'h1c
`define A_G1_ON 5'h1d
`define A_B1_OFF 5'h1e
`define A_B1_ON 5'h1f
`define MAP_TOP 8'h1f
`define ADDR_STATUS 8'h80
`define REG_RESET 8'h00
`define BIT_STANDBY 0
`define BIT_REG_EN 1
`define BIT_FIXED_V 2
`define MASK_CODE 8'h1f
`define MASK_SIX 8'h3f
`define MASK_PULSE 8'h7f
`define MASK_FULL 8'hff
`define GATE_ONE 8'hf8
`define GATE_TWO 8'h0e
`define GATE_THREE 8'h77
`define GATE_FOUR 8'hff
`define ST_BOOST 0
`define ST_THERM 1
`define ST_SCP 2
`define ST_HLIM 3
`define ST_ACCEPT 4
`define SCP_TIME_MS 10
`define CLK_PERIOD_NS 4
`define SCP_CYCLES ((`SCP_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define FRAME_LAST 5'd15
`endif

// ### led_ctl_pkg.sv
// types shared by the led driver control bank
package led_ctl_pkg;
    // serial link receive states
    typedef enum logic [1:0] {LINK_IDLE, LINK_SHIFT, LINK_WAIT} link_state_e;

    // whole state of the top module
    typedef struct packed {
        link_state_e link_st;
        logic [4:0] bit_cnt;
        logic [15:0] shift;
        logic lclk_prev;
        logic pend;
        logic [7:0] pend_addr;
        logic [7:0] pend_data;
        logic therm_hold;
        logic scp_latch;
        logic [21:0] scp_cnt;
        logic [7:0] rdata;
    } ctl_state_s;
endpackage

// ### led_sync.sv
// two flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module led_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // async in, synced out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    // first stage feeds only the second
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_s;
    sync_state_s st;
    sync_state_s next_st;

    // shift one stage per edge
    always_comb
    begin
        next_st.s1 = i_async;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_sync = st.s2;
endmodule
`default_nettype wire

// ### led_reg_store.sv
// thirty-two byte write only register store with parallel image
`include "led_ctl_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module led_reg_store (
    // clock and resets
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_clear,
    // write port
    input wire logic i_we,
    input wire logic [4:0] i_waddr,
    input wire logic [7:0] i_wdata,
    // every byte, straight from flops
    output logic [255:0] o_image
);
    typedef struct packed {
        logic [31:0][7:0] mem;
    } store_state_s;
    store_state_s st;
    store_state_s next_st;

    // clear wins over a write in the same cycle
    always_comb
    begin
        next_st = st;
        if (i_clear)
            next_st.mem = {32{`REG_RESET}};
        else if (i_we)
            next_st.mem[i_waddr] = i_wdata;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            st <= {32{`REG_RESET}};
        else
            st <= next_st;
    end

    assign o_image = st.mem;
endmodule
`default_nettype wire

// ### led_driver_control_regs.sv
// control registers and protection sequencing of the led driver
`include "led_ctl_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module led_driver_control_regs #(
    // droop persistence in cycles, shorten for simulation
    parameter logic [21:0] SCP_CYCLES = 22'(`SCP_CYCLES)
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // serial link pins
    input wire logic i_link_clk,
    input wire logic i_link_sel,
    input wire logic i_link_data,
    // supply, reset pin and analog monitors
    input wire logic i_reset_pin_n,
    input wire logic i_vdd_ok,
    input wire logic i_over_temp,
    input wire logic i_in_high,
    input wire logic i_out_droop,
    input wire logic i_pin_droop,
    // protection results
    output logic o_boost_run,
    output logic o_led_blank,
    output logic o_short_circuit_latch,
    output logic o_h_limit_stop,
    // register contents
    output logic [7:0] o_led_settings_one,
    output logic [7:0] o_led_settings_two,
    output logic [7:0] o_led_settings_three,
    output logic [7:0] o_led_settings_four,
    output logic [7:0] o_main_backlight_current,
    output logic [7:0] o_main_ch4_current,
    output logic [7:0] o_main_ch5_current,
    output logic [7:0] o_main_ch6_current_voltage,
    output logic [7:0] o_sub_ch1_current,
    output logic [7:0] o_sub_ch2_current,
    output logic [7:0] o_red1_current,
    output logic [7:0] o_green1_current,
    output logic [7:0] o_blue1_current,
    output logic [7:0] o_red2_current,
    output logic [7:0] o_green2_current,
    output logic [7:0] o_blue2_current,
    output logic [7:0] o_flash1_current,
    output logic [7:0] o_flash2_current,
    output logic [7:0] o_flash3_current,
    output logic [7:0] o_main_fade_time,
    output logic [7:0] o_sub_fade_time,
    output logic [7:0] o_red1_fade_time,
    output logic [7:0] o_green1_fade_time,
    output logic [7:0] o_blue1_fade_time,
    output logic [7:0] o_tricolor1_gradation,
    output logic [7:0] o_tricolor1_pulse_mode,
    output logic [7:0] o_red1_off_position,
    output logic [7:0] o_red1_on_position,
    output logic [7:0] o_green1_off_position,
    output logic [7:0] o_green1_on_position,
    output logic [7:0] o_blue1_off_position,
    output logic [7:0] o_blue1_on_position
);
    // bits of each register that really exist
    function automatic logic [7:0] wmask(input logic [4:0] a);
        logic [7:0] m;
        m = `MASK_FULL;
        unique case (a)
            // single byte control and range registers
            `A_SET_ONE, `A_SET_TWO, `A_SET_THREE, `A_SET_FOUR:
                m = `MASK_FULL;
            `A_MAIN_CUR, `A_M6_CUR:
                m = `MASK_FULL;
            `A_R1_CUR, `A_R2_CUR, `A_F1_CUR:
                m = `MASK_FULL;
            `A_GRAD:
                m = `MASK_FULL;
            // plain current codes, top three bits unused
            `A_M4_CUR, `A_M5_CUR, `A_S1_CUR, `A_S2_CUR, `A_G1_CUR,
            `A_B1_CUR, `A_G2_CUR, `A_B2_CUR, `A_F2_CUR, `A_F3_CUR:
                m = `MASK_CODE;
            // fade times, two top bits unused
            `A_MAIN_FADE, `A_SUB_FADE, `A_R1_FADE, `A_G1_FADE, `A_B1_FADE:
                m = `MASK_SIX;
            `A_PULSE:
                m = `MASK_PULSE;
            // six bit positions
            `A_R1_OFF, `A_R1_ON, `A_G1_OFF, `A_G1_ON, `A_B1_OFF, `A_B1_ON:
                m = `MASK_SIX;
        endcase
        return m;
    endfunction

    // synchronised pins
    logic [8:0] pins_sync;
    logic s_lclk;
    logic s_lsel;
    logic s_ldata;
    logic s_rst_pin_n;
    logic s_vdd_ok;
    logic s_hot;
    logic s_in_high;
    logic s_out_droop;
    logic s_pin_droop;

    // every pin passes two flops before use
    led_sync #(
        .W(9)
    ) u_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_async({i_link_clk, i_link_sel, i_link_data, i_reset_pin_n,
                  i_vdd_ok, i_over_temp, i_in_high, i_out_droop,
                  i_pin_droop}),
        .o_sync(pins_sync)
    );
    assign {s_lclk, s_lsel, s_ldata, s_rst_pin_n, s_vdd_ok, s_hot,
            s_in_high, s_out_droop, s_pin_droop} = pins_sync;

    // address inside the write only map
    function automatic logic in_map(input logic [7:0] a);
        return a <= `MAP_TOP;
    endfunction

    // whole state of the bank, registered once per edge
    led_ctl_pkg::ctl_state_s st;
    led_ctl_pkg::ctl_state_s next_st;

    // register store ports and its byte image
    logic [255:0] image; // byte n sits at bits 8n+7 to 8n
    logic store_we; // one byte written this cycle
    logic [4:0] store_addr; // byte being written
    logic [7:0] store_data; // masked byte being written
    logic store_clear; // reset pin seen with supply present

    // decoded control and protection terms
    logic reg_en; // regulator enable bit of settings one
    logic fixed_mode; // fixed voltage mode bit of settings one
    logic droop; // droop of the monitor picked by the mode
    logic lclk_rise; // rising edge of the synced link clock
    logic pend_go; // pending frame byte may use the store
    logic clr_write; // write of zero to the regulator enable
    logic scp_set; // droop timer expires this cycle
    logic boost_run; // step-up may switch
    logic [7:0] status; // protection flags for reads

    // the store keeps every map byte, read back as a flat image
    led_reg_store u_store (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_clear(store_clear),
        .i_we(store_we),
        .i_waddr(store_addr),
        .i_wdata(store_data),
        .o_image(image)
    );

    // settings one lives in byte zero of the image
    assign reg_en = image[`BIT_REG_EN];
    assign fixed_mode = image[`BIT_FIXED_V];

    // edge found by comparing with last sampled level
    assign lclk_rise = s_lclk && !st.lclk_prev;

    // the register port always wins, a frame byte waits while i_wr is high
    assign pend_go = st.pend && !i_wr;

    // reset pin has no effect without logic supply
    assign store_clear = !s_rst_pin_n && s_vdd_ok;

    // in fixed mode the led pin is watched, else the output
    assign droop = fixed_mode ? s_pin_droop : s_out_droop;

    // write source selection; no supply means no write at all
    always_comb
    begin
        store_we = 1'b0;
        store_addr = 5'h00;
        store_data = 8'h00;
        if (s_vdd_ok && i_wr && in_map(i_addr))
        begin
            // register port, unused bits dropped here
            store_we = 1'b1;
            store_addr = i_addr[4:0];
            store_data = i_wdata & wmask(i_addr[4:0]);
        end
        else if (s_vdd_ok && pend_go && in_map(st.pend_addr))
        begin
            // whole byte from the link, never a partial one
            store_we = 1'b1;
            store_addr = st.pend_addr[4:0];
            store_data = st.pend_data & wmask(st.pend_addr[4:0]);
        end
    end

    // a stored zero in the enable bit clears the latch
    assign clr_write = store_we && store_addr == `A_SET_ONE
                       && !store_data[`BIT_REG_EN];

    // timer end: droop held for the whole persistence time
    assign scp_set = reg_en && droop && !st.scp_latch
                     && st.scp_cnt == SCP_CYCLES - 22'd1;

    // boost stops on overheat, latch or input high limit
    assign boost_run = reg_en && !st.therm_hold && !st.scp_latch
                       && !s_in_high;

    // flags offered on a read of the status address
    always_comb
    begin
        status = 8'h00;
        status[`ST_BOOST] = boost_run;
        status[`ST_THERM] = st.therm_hold;
        status[`ST_SCP] = st.scp_latch;
        status[`ST_HLIM] = s_in_high;
        status[`ST_ACCEPT] = s_vdd_ok;
    end

    // next state: link receiver, protection and read data
    always_comb
    begin
        next_st = st;
        next_st.lclk_prev = s_lclk;
        // read data stand for one cycle only
        next_st.rdata = 8'h00;
        if (i_rd)
        begin
            // map bytes are write only and read as zero
            if (i_addr == `ADDR_STATUS)
                next_st.rdata = status;
            else
                next_st.rdata = 8'h00;
        end
        // a pending byte is used once, or lost with the supply
        if (pend_go || !s_vdd_ok)
            next_st.pend = 1'b0;
        // link receiver, msb first, address byte then data
        unique case (st.link_st)
            led_ctl_pkg::LINK_IDLE:
            begin
                // frames only start with logic supply present
                if (s_lsel && s_vdd_ok)
                begin
                    next_st.link_st = led_ctl_pkg::LINK_SHIFT;
                    next_st.bit_cnt = 5'd0;
                end
            end
            led_ctl_pkg::LINK_SHIFT:
            begin
                // a cut frame is dropped, nothing half written
                if (!s_lsel || !s_vdd_ok)
                    next_st.link_st = led_ctl_pkg::LINK_IDLE;
                else if (lclk_rise)
                begin
                    next_st.shift = {st.shift[14:0], s_ldata};
                    next_st.bit_cnt = st.bit_cnt + 5'd1;
                    if (st.bit_cnt == `FRAME_LAST)
                    begin
                        // sixteenth bit: hand over the whole byte
                        next_st.pend = 1'b1;
                        next_st.pend_addr = st.shift[14:7];
                        next_st.pend_data = {st.shift[6:0], s_ldata};
                        next_st.link_st = led_ctl_pkg::LINK_WAIT;
                    end
                end
            end
            led_ctl_pkg::LINK_WAIT:
            begin
                // extra clocks before deselect are ignored
                if (!s_lsel)
                    next_st.link_st = led_ctl_pkg::LINK_IDLE;
            end
            default:
                next_st.link_st = led_ctl_pkg::LINK_IDLE;
        endcase
        // overheat hold; a latched short keeps it from lifting
        next_st.therm_hold = s_hot
                             || (st.therm_hold && st.scp_latch);
        // droop timer runs only while the regulator is enabled
        if (reg_en && droop && !st.scp_latch)
            next_st.scp_cnt = st.scp_cnt + 22'd1;
        else
            next_st.scp_cnt = 22'd0;
        // latch set wins over a clear in the same cycle
        if (scp_set)
        begin
            next_st.scp_latch = 1'b1;
            next_st.scp_cnt = 22'd0;
        end
        else if (clr_write || store_clear)
            next_st.scp_latch = 1'b0;
    end

    // one register for the whole state, constants on reset
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            st <= '0;
        else
            st <= next_st;
    end

    // protection results and read data
    assign o_boost_run = boost_run;
    assign o_led_blank = st.therm_hold;
    assign o_short_circuit_latch = st.scp_latch;
    assign o_h_limit_stop = s_in_high;
    assign o_rdata = st.rdata;

    // register contents, straight from the store flops
    assign o_led_settings_one = image[7:0];
    assign o_led_settings_two = image[15:8];
    assign o_led_settings_three = image[23:16];
    assign o_led_settings_four = image[31:24];
    assign o_main_backlight_current = image[39:32];
    assign o_main_ch4_current = image[47:40];
    assign o_main_ch5_current = image[55:48];
    assign o_main_ch6_current_voltage = image[63:56];
    assign o_sub_ch1_current = image[71:64];
    assign o_sub_ch2_current = image[79:72];
    assign o_red1_current = image[87:80];
    assign o_green1_current = image[95:88];
    assign o_blue1_current = image[103:96];
    assign o_red2_current = image[111:104];
    assign o_green2_current = image[119:112];
    assign o_blue2_current = image[127:120];
    assign o_flash1_current = image[135:128];
    assign o_flash2_current = image[143:136];
    assign o_flash3_current = image[151:144];
    assign o_main_fade_time = image[159:152];
    assign o_sub_fade_time = image[167:160];
    assign o_red1_fade_time = image[175:168];
    assign o_green1_fade_time = image[183:176];
    assign o_blue1_fade_time = image[191:184];
    assign o_tricolor1_gradation = image[199:192];
    assign o_tricolor1_pulse_mode = image[207:200];
    assign o_red1_off_position = image[215:208];
    assign o_red1_on_position = image[223:216];
    assign o_green1_off_position = image[231:224];
    assign o_green1_on_position = image[239:232];
    assign o_blue1_off_position = image[247:240];
    assign o_blue1_on_position = image[255:248];
endmodule
`default_nettype wire

// ### led_host_link.sv
// serial host model driving the link pins of the led bank
`timescale 1ns/100ps
`default_nettype none
module led_host_link (
    // link pins toward the bank
    output logic o_clk,
    output logic o_sel,
    output logic o_data
);
    // link idle: clock still, not selected
    initial
    begin
        o_clk = 1'b0;
        o_sel = 1'b0;
        o_data = 1'b0;
    end
    // one frame, address then data, msb first, 48 ns clock
    task automatic send(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] f;
        f = {a, d};
        #3 o_sel = 1'b1;
        for (int i = 15; i >= 0; i--)
        begin
            o_data = f[i];
            #24 o_clk = 1'b1;
            #24 o_clk = 1'b0;
        end
        // released line flips so a stale bit cannot pass
        o_data = ~o_data;
        #24 o_sel = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### led_driver_control_regs_properties.sv
// assertions on the ports of the led control bank
`timescale 1ns/100ps
`default_nettype none
module led_ctl_properties #(
    parameter logic [21:0] SCP_CYCLES = 22'd20
) (
    // clock, reset and inputs
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_vdd_ok,
    input wire logic i_over_temp,
    input wire logic i_in_high,
    input wire logic i_out_droop,
    input wire logic i_pin_droop,
    // outputs watched
    input wire logic o_boost_run,
    input wire logic o_led_blank,
    input wire logic o_short_circuit_latch,
    input wire logic o_h_limit_stop,
    input wire logic [7:0] o_led_settings_one,
    input wire logic [7:0] o_main_backlight_current,
    input wire logic [7:0] o_main_ch4_current
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic [21:0] droop_cnt; // unbroken droop cycles, saturating
    // raw inputs counted, so sync delay only adds margin
    always_ff @(posedge i_clk)
        if (i_srst || !(i_out_droop || i_pin_droop))
            droop_cnt <= '0;
        else if (droop_cnt != '1)
            droop_cnt <= droop_cnt + 22'd1;
    a_therm_blank: assert property (i_over_temp [*5] |-> o_led_blank)
        else $error("leds not blanked in overheat");
    a_hlim_stop: assert property (i_in_high [*5] |-> o_h_limit_stop)
        else $error("boost not held at input high");
    a_scp_stop: assert property (o_short_circuit_latch |-> !o_boost_run)
        else $error("boost runs while latched");
    a_scp_timer: assert property ($rose(o_short_circuit_latch)
        |-> droop_cnt >= SCP_CYCLES) else $error("latch set early");
    a_scp_hold: assert property (o_short_circuit_latch && !i_wr
        && !$past(i_wr) |=> o_short_circuit_latch) else $error("latch lost");
    a_scp_clear: assert property (i_wr && i_vdd_ok && i_addr == 8'h00
        && !i_wdata[1] |-> ##[1:3] !o_short_circuit_latch)
        else $error("latch not cleared");
    a_write_store: assert property (i_wr && i_vdd_ok && i_addr == 8'h04
        |=> o_main_backlight_current == $past(i_wdata))
        else $error("byte not stored");
    a_unused_zero: assert property (o_main_ch4_current[7:5] == 3'h0)
        else $error("unused bits stored");
    a_reset_zero: assert property ($fell(i_srst) |-> o_led_settings_one == 0)
        else $error("register not zero after reset");
    cover property ($rose(o_short_circuit_latch));
    cover property ($rose(o_led_blank));
    cover property ($rose(o_h_limit_stop));
endmodule
bind led_driver_control_regs led_ctl_properties #(
    .SCP_CYCLES(SCP_CYCLES)) u_props (.*);
`default_nettype wire

// ### led_driver_control_regs_tb.sv
// self-checking bench for the led control bank
`timescale 1ns/100ps
`default_nettype none
module led_driver_control_regs_tb;
    logic i_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic i_reset_pin_n = 1'b1, i_vdd_ok = 1'b1, i_over_temp = 1'b0;
    logic i_in_high = 1'b0, i_out_droop = 1'b0, i_pin_droop = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    wire i_link_clk, i_link_sel, i_link_data;
    logic o_boost_run, o_led_blank, o_short_circuit_latch, o_h_limit_stop;
    logic [7:0] o_led_settings_one, o_led_settings_two, o_led_settings_three,
        o_led_settings_four, o_main_backlight_current, o_main_ch4_current,
        o_main_ch5_current, o_main_ch6_current_voltage, o_sub_ch1_current,
        o_sub_ch2_current, o_red1_current, o_green1_current, o_blue1_current,
        o_red2_current, o_green2_current, o_blue2_current, o_flash1_current,
        o_flash2_current, o_flash3_current, o_main_fade_time, o_sub_fade_time,
        o_red1_fade_time, o_green1_fade_time, o_blue1_fade_time,
        o_tricolor1_gradation, o_tricolor1_pulse_mode, o_red1_off_position,
        o_red1_on_position, o_green1_off_position, o_green1_on_position,
        o_blue1_off_position, o_blue1_on_position;
    int n_fail = 0;
    int checked = 0;
    always #2 i_clk = ~i_clk;
    // short droop time keeps the run brief
    led_driver_control_regs #(.SCP_CYCLES(22'd20)) dut (.*);
    led_host_link host (.o_clk(i_link_clk), .o_sel(i_link_sel),
        .o_data(i_link_data));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // one cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask
    // longer than droop time plus synchroniser delay
    task automatic settle();
        repeat (30) @(posedge i_clk);
    endtask
    task automatic final_report();
        if (n_fail == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // field masks on full writes
    task automatic t_regs();
        wr(8'h05, 8'hff);
        wr(8'h07, 8'hff);
        wr(8'h13, 8'hff);
        wr(8'h19, 8'hff);
        wr(8'h1f, 8'hff);
        wr(8'h03, 8'ha5);
        settle();
        check(o_main_ch4_current, 8'h1f);
        check(o_main_ch6_current_voltage, 8'hff);
        check(o_main_fade_time, 8'h3f);
        check(o_tricolor1_pulse_mode, 8'h7f);
        check(o_blue1_on_position, 8'h3f);
        check(o_led_settings_four, 8'ha5);
    endtask
    // frames over the link, then without logic supply
    task automatic t_link();
        host.send(8'h04, 8'ha5);
        settle();
        check(o_main_backlight_current, 8'ha5);
        i_vdd_ok <= 1'b0;
        host.send(8'h09, 8'h11);
        settle();
        check(o_sub_ch2_current, 8'h00);
        i_vdd_ok <= 1'b1;
        settle();
    endtask
    // overheat, latched droop, input high
    task automatic t_prot();
        logic [7:0] d;
        wr(8'h00, 8'h02); // leds off when regulator starts
        i_over_temp <= 1'b1;
        settle();
        check(o_led_blank, 8'h01);
        check(o_boost_run, 8'h00);
        check(o_led_settings_one, 8'h02);
        i_over_temp <= 1'b0;
        settle();
        check(o_boost_run, 8'h01);
        i_out_droop <= 1'b1;
        settle();
        i_out_droop <= 1'b0;
        i_over_temp <= 1'b1;
        settle();
        i_over_temp <= 1'b0;
        settle();
        check(o_boost_run, 8'h00);
        check(o_short_circuit_latch, 8'h01);
        rd(8'h80, d);
        check(d, 8'h16);
        rd(8'h05, d);
        check(d, 8'h00);
        wr(8'h00, 8'h00);
        settle();
        check(o_short_circuit_latch, 8'h00);
        wr(8'h01, 8'h01); // channels stay off before reuse
        wr(8'h00, 8'h06);
        i_pin_droop <= 1'b1;
        settle();
        check(o_short_circuit_latch, 8'h01);
        i_pin_droop <= 1'b0;
        i_srst <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_srst <= 1'b0;
        settle();
        check(o_short_circuit_latch, 8'h00);
        check(o_led_settings_one, 8'h00);
        wr(8'h00, 8'h02);
        i_in_high <= 1'b1;
        settle();
        check(o_h_limit_stop, 8'h01);
        check(o_boost_run, 8'h00);
        i_in_high <= 1'b0;
        settle();
        check(o_boost_run, 8'h01);
        wr(8'h05, 8'h11);
        i_reset_pin_n <= 1'b0;
        settle();
        check(o_main_ch4_current, 8'h00);
        i_reset_pin_n <= 1'b1; // released with supplies up
        settle();
    endtask
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_srst <= 1'b0;
        settle();
        t_regs();
        t_link();
        t_prot();
        final_report();
    end
endmodule
`default_nettype wire
